// File: design/pmrp_regs.vh
// register page offsets, identification register values, partition and monitor counts, error codes
`ifndef PMRP_REGS_VH
`define PMRP_REGS_VH
`define PMRP_PAGE_BITS       16
`define PMRP_OFF_FEATURE_ID  16'h0000
`define PMRP_OFF_SEC_FEAT_ID 16'h0008
`define PMRP_OFF_IMPL_ID     16'h0018
`define PMRP_OFF_ARCH_ID     16'h0020
`define PMRP_OFF_MON_FEAT_ID 16'h0080
`define PMRP_OFF_ERR_CTL     16'h00F0
`define PMRP_OFF_ERR_STAT    16'h00F8
`define PMRP_OFF_PART_SEL    16'h0100
`define PMRP_OFF_CACHE_MAX   16'h0108
`define PMRP_OFF_PRIORITY    16'h0400
`define PMRP_OFF_MON_SEL     16'h0800
`define PMRP_OFF_CSU_FLT     16'h0810
`define PMRP_OFF_CSU_CTL     16'h0818
`define PMRP_OFF_CSU_CNT     16'h0840
`define PMRP_OFF_CSU_CAPT    16'h0848
`define PMRP_OFF_IMPL_BASE   16'h3000
`define PMRP_NUM_PARTS       8
`define PMRP_PART_BITS       3
`define PMRP_NUM_MONS        4
`define PMRP_MON_BITS        2
`define PMRP_FEATURE_VAL     32'h0001_0107
`define PMRP_SEC_FEAT_VAL    32'h0000_0007
`define PMRP_IMPL_ID_VAL     32'h0000_0A5A
`define PMRP_ARCH_ID_VAL     32'h0000_0010
`define PMRP_MON_FEAT_VAL    32'h0001_0000
`define PMRP_ERR_SEL_RANGE   4'h1
`define PMRP_ERR_MON_RANGE   4'h2
`endif

// File: design/pmrp_bank.v
// one security bank: selection registers, per-partition and per-monitor storage
`default_nettype none
module pmrp_bank (
  input  wire        clk,
  input  wire        rst,
  input  wire        wr_en,
  input  wire [15:0] offset,
  input  wire [31:0] wdata,
  input  wire [3:0]  err_code,
  input  wire        err_set,
  input  wire        mon_event,
  output reg  [31:0] rdata,
  output reg         hit
);
`include "pmrp_regs.vh"
  reg [31:0] err_ctl_reg;
  reg [31:0] err_stat_reg;
  reg [`PMRP_PART_BITS-1:0] part_sel_reg;
  reg [`PMRP_MON_BITS-1:0]  mon_sel_reg;
  reg [31:0] cache_max_mem [0:`PMRP_NUM_PARTS-1];
  reg [31:0] priority_mem  [0:`PMRP_NUM_PARTS-1];
  reg [31:0] csu_flt_mem   [0:`PMRP_NUM_MONS-1];
  reg [31:0] csu_ctl_mem   [0:`PMRP_NUM_MONS-1];
  reg [31:0] csu_cnt_mem   [0:`PMRP_NUM_MONS-1];
  reg [31:0] csu_capt_mem  [0:`PMRP_NUM_MONS-1];
  integer i;

  always @(posedge clk) begin
    if (rst) begin
      err_ctl_reg  <= 32'h0;
      err_stat_reg <= 32'h0;
      part_sel_reg <= {`PMRP_PART_BITS{1'b0}};
      mon_sel_reg  <= {`PMRP_MON_BITS{1'b0}};
      for (i = 0; i < `PMRP_NUM_PARTS; i = i + 1) begin
        cache_max_mem[i] <= 32'h0;
        priority_mem[i]  <= 32'h0;
      end
      for (i = 0; i < `PMRP_NUM_MONS; i = i + 1) begin
        csu_flt_mem[i]  <= 32'h0;
        csu_ctl_mem[i]  <= 32'h0;
        csu_cnt_mem[i]  <= 32'h0;
        csu_capt_mem[i] <= 32'h0;
      end
    end else begin
      // enabled monitors count events; bit 31 of control is enable
      for (i = 0; i < `PMRP_NUM_MONS; i = i + 1) begin
        if (mon_event && csu_ctl_mem[i][31])
          csu_cnt_mem[i] <= csu_cnt_mem[i] + 32'h1;
      end
      if (wr_en) begin
        if (offset == `PMRP_OFF_ERR_CTL)
          err_ctl_reg <= wdata;
        else if (offset == `PMRP_OFF_ERR_STAT)
          err_stat_reg <= wdata;
        else if (offset == `PMRP_OFF_PART_SEL)
          part_sel_reg <= wdata[`PMRP_PART_BITS-1:0];
        else if (offset == `PMRP_OFF_CACHE_MAX)
          cache_max_mem[part_sel_reg] <= wdata;
        else if (offset == `PMRP_OFF_PRIORITY)
          priority_mem[part_sel_reg] <= wdata;
        else if (offset == `PMRP_OFF_MON_SEL)
          mon_sel_reg <= wdata[`PMRP_MON_BITS-1:0];
        else if (offset == `PMRP_OFF_CSU_FLT)
          csu_flt_mem[mon_sel_reg] <= wdata;
        else if (offset == `PMRP_OFF_CSU_CTL)
          csu_ctl_mem[mon_sel_reg] <= wdata;
        else if (offset == `PMRP_OFF_CSU_CNT)
          csu_cnt_mem[mon_sel_reg] <= wdata;
        else if (offset == `PMRP_OFF_CSU_CAPT)
          csu_capt_mem[mon_sel_reg] <= wdata;
      end
      // a detected error wins over a software write to the status
      if (err_set)
        err_stat_reg <= {28'h0, err_code};
    end
  end

  always @* begin
    rdata = 32'h0;
    hit   = 1'b1;
    if (offset == `PMRP_OFF_ERR_CTL)
      rdata = err_ctl_reg;
    else if (offset == `PMRP_OFF_ERR_STAT)
      rdata = err_stat_reg;
    else if (offset == `PMRP_OFF_PART_SEL)
      rdata = {{(32-`PMRP_PART_BITS){1'b0}}, part_sel_reg};
    else if (offset == `PMRP_OFF_CACHE_MAX)
      rdata = cache_max_mem[part_sel_reg];
    else if (offset == `PMRP_OFF_PRIORITY)
      rdata = priority_mem[part_sel_reg];
    else if (offset == `PMRP_OFF_MON_SEL)
      rdata = {{(32-`PMRP_MON_BITS){1'b0}}, mon_sel_reg};
    else if (offset == `PMRP_OFF_CSU_FLT)
      rdata = csu_flt_mem[mon_sel_reg];
    else if (offset == `PMRP_OFF_CSU_CTL)
      rdata = csu_ctl_mem[mon_sel_reg];
    else if (offset == `PMRP_OFF_CSU_CNT)
      rdata = csu_cnt_mem[mon_sel_reg];
    else if (offset == `PMRP_OFF_CSU_CAPT)
      rdata = csu_capt_mem[mon_sel_reg];
    else
      hit = 1'b0;
  end
endmodule // pmrp_bank
`default_nettype wire

// File: design/pmrp_page.v
// partition monitor register page: decode, security banking, reserved handling
// What this block does
// - monitor select write picks configured instance
// - counter and capture also indexed by select
// - separate Secure and Non-secure monitor selects
// - all registers in one 64 KB page
// - page answers in both security spaces
// - Secure ids only Secure, Non-secure only Non-secure
// - partition config registers banked by security
// - Secure feature id hidden from Non-secure
// - identical read-only feature id may be shared
// - implementation and architecture ids shared
// - differing id registers banked per space
// - control absent in one space may be omitted
// - error, select, config, monitor registers banked
// - no register in space means reserved access
// - feature, arch, impl, Secure ids implemented
// - controls present so partition select implemented
// - monitors present so monitor id and select
// - errors detected so status and control implemented
// - optional registers only for present features
// - reserved reads zero, writes ignored
// - offsets 0x3000 and above answer reserved, no implementation registers
// - feature id at page offset zero
`default_nettype none
module pmrp_page (
  input  wire        clk,
  input  wire        rst,
  input  wire        req_valid,
  input  wire        req_write,
  input  wire [15:0] req_addr,
  input  wire [31:0] req_wdata,
  input  wire        nonsecure_attr,
  input  wire        mon_event,
  output reg         resp_valid,
  output reg  [31:0] resp_rdata,
  output reg         resp_reserved
);
`include "pmrp_regs.vh"
  // req_addr is the byte offset inside the 64 KB aligned page
  wire [15:0] off = {req_addr[15:2], 2'b00};
  wire        wr  = req_valid && req_write;
  wire [31:0] s_rdata;
  wire [31:0] ns_rdata;
  wire        s_hit;
  wire        ns_hit;
  reg  [31:0] id_rdata;
  reg         id_hit;
  reg  [31:0] rdata_next;
  reg         reserved_next;
  reg         s_err;
  reg         ns_err;
  reg  [3:0]  err_code;

  // out-of-range selection write is flagged in that bank's error status
  always @* begin
    err_code = 4'h0;
    if (wr && off == `PMRP_OFF_PART_SEL && req_wdata >= `PMRP_NUM_PARTS)
      err_code = `PMRP_ERR_SEL_RANGE;
    else if (wr && off == `PMRP_OFF_MON_SEL && req_wdata >= `PMRP_NUM_MONS)
      err_code = `PMRP_ERR_MON_RANGE;
    s_err  = (err_code != 4'h0) && !nonsecure_attr;
    ns_err = (err_code != 4'h0) && nonsecure_attr;
  end

  pmrp_bank u_sec_bank (
    .clk       (clk),
    .rst       (rst),
    .wr_en     (wr && !nonsecure_attr),
    .offset    (off),
    .wdata     (req_wdata),
    .err_code  (err_code),
    .err_set   (s_err),
    .mon_event (mon_event),
    .rdata     (s_rdata),
    .hit       (s_hit)
  );

  pmrp_bank u_ns_bank (
    .clk       (clk),
    .rst       (rst),
    .wr_en     (wr && nonsecure_attr),
    .offset    (off),
    .wdata     (req_wdata),
    .err_code  (err_code),
    .err_set   (ns_err),
    .mon_event (mon_event),
    .rdata     (ns_rdata),
    .hit       (ns_hit)
  );

  // read-only identification registers, shared unless noted
  always @* begin
    id_rdata = 32'h0;
    id_hit   = 1'b1;
    if (off == `PMRP_OFF_FEATURE_ID)
      id_rdata = `PMRP_FEATURE_VAL;
    else if (off == `PMRP_OFF_SEC_FEAT_ID && !nonsecure_attr)
      id_rdata = `PMRP_SEC_FEAT_VAL;
    else if (off == `PMRP_OFF_IMPL_ID)
      id_rdata = `PMRP_IMPL_ID_VAL;
    else if (off == `PMRP_OFF_ARCH_ID)
      id_rdata = `PMRP_ARCH_ID_VAL;
    else if (off == `PMRP_OFF_MON_FEAT_ID)
      id_rdata = `PMRP_MON_FEAT_VAL;
    else
      id_hit = 1'b0;
  end

  // choose bank by attribute only; unmatched or write-to-id is reserved
  always @* begin
    rdata_next    = 32'h0;
    reserved_next = 1'b0;
    if (off >= `PMRP_OFF_IMPL_BASE)
      reserved_next = 1'b1;
    else if (id_hit) begin
      if (req_write)
        reserved_next = 1'b1;
      else
        rdata_next = id_rdata;
    end else if (nonsecure_attr && ns_hit) begin
      rdata_next = ns_rdata;
    end else if (!nonsecure_attr && s_hit) begin
      rdata_next = s_rdata;
    end else
      reserved_next = 1'b1;
    if (reserved_next || req_write)
      rdata_next = 32'h0;
  end

  always @(posedge clk) begin
    if (rst) begin
      resp_valid    <= 1'b0;
      resp_rdata    <= 32'h0;
      resp_reserved <= 1'b0;
    end else begin
      resp_valid    <= req_valid;
      resp_rdata    <= req_valid ? rdata_next : 32'h0;
      resp_reserved <= req_valid && reserved_next;
    end
  end
endmodule // pmrp_page
`default_nettype wire

// File: testbench/pmrp_chk.sv
// concurrent checks on the register page ports
`default_nettype none
`include "pmrp_regs.vh"
module pmrp_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic [15:0] req_addr,
  input wire logic        nonsecure_attr,
  input wire logic        resp_valid,
  input wire logic [31:0] resp_rdata,
  input wire logic        resp_reserved
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic rd = req_valid && !req_write;
  a_answer_next: assert property (req_valid |=> resp_valid) else $error("no answer");
  a_no_stray: assert property (!req_valid |=> !resp_valid) else $error("stray answer");
  a_upper_reserved: assert property (
    req_valid && req_addr >= `PMRP_OFF_IMPL_BASE |=> resp_reserved && resp_rdata == 32'h0)
    else $error("upper page answered");
  a_reserved_zero: assert property (
    resp_reserved |-> resp_valid && resp_rdata == 32'h0) else $error("reserved data");
  a_write_zero: assert property (
    req_valid && req_write |=> resp_rdata == 32'h0) else $error("write returned data");
  a_feature_at_zero: assert property (
    rd && req_addr[15:2] == 14'h0 |=> !resp_reserved && resp_rdata == `PMRP_FEATURE_VAL)
    else $error("feature id wrong");
  a_sec_id_hidden: assert property (
    rd && req_addr[15:2] == 14'h2 |=> resp_reserved == $past(nonsecure_attr))
    else $error("secure id visibility wrong");
  a_impl_shared: assert property (
    rd && req_addr[15:2] == 14'h6 |=> resp_rdata == `PMRP_IMPL_ID_VAL) else $error("impl id");
  a_arch_shared: assert property (
    rd && req_addr[15:2] == 14'h8 |=> resp_rdata == `PMRP_ARCH_ID_VAL) else $error("arch id");
  c_ns_hidden: cover property (rd && nonsecure_attr && req_addr[15:2] == 14'h2);
  c_upper: cover property (req_valid && req_addr >= 16'h3000);
  c_write: cover property (req_valid && req_write ##1 resp_valid);
endmodule // pmrp_chk
bind pmrp_page pmrp_chk u_chk (.clk(clk), .rst(rst), .req_valid(req_valid),
  .req_write(req_write), .req_addr(req_addr), .nonsecure_attr(nonsecure_attr),
  .resp_valid(resp_valid), .resp_rdata(resp_rdata), .resp_reserved(resp_reserved));
`default_nettype wire

// File: testbench/pmrp_host.sv
// interconnect model issuing single register accesses
`default_nettype none
module pmrp_host (
  input  wire logic        clk,
  output var  logic        req_valid,
  output var  logic        req_write,
  output var  logic [15:0] req_addr,
  output var  logic [31:0] req_wdata,
  output var  logic        nonsecure_attr,
  input  wire logic        resp_valid,
  input  wire logic [31:0] resp_rdata,
  input  wire logic        resp_reserved
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {req_valid, req_write, req_addr, req_wdata, nonsecure_attr} = 51'h0;
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic ns, output logic [33:0] r);
    @(negedge clk);
    {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
    nonsecure_attr = ns;
    @(negedge clk);
    r = {resp_valid, resp_reserved, resp_rdata};
    // idle lines flip so stale values cannot pass
    {req_valid, req_write, req_addr, req_wdata} = {1'b0, ~w, ~a, ~d};
  endtask
endmodule // pmrp_host
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the register page
`default_nettype none
`include "pmrp_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, mon_event = 1'b0;
  logic        req_valid, req_write, nonsecure_attr, resp_valid, resp_reserved;
  logic [15:0] req_addr;
  logic [31:0] req_wdata, resp_rdata, rs;
  logic [31:0] v[5][16];
  logic [15:0] off[5] = '{`PMRP_OFF_CACHE_MAX, `PMRP_OFF_CSU_CTL, `PMRP_OFF_CSU_FLT,
                          `PMRP_OFF_PRIORITY, `PMRP_OFF_CSU_CAPT};
  int          n_mismatch = 0, num_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  pmrp_host host (.clk(clk), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .nonsecure_attr(nonsecure_attr),
    .resp_valid(resp_valid), .resp_rdata(resp_rdata), .resp_reserved(resp_reserved));
  pmrp_page DUT (.clk(clk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .nonsecure_attr(nonsecure_attr),
    .mon_event(mon_event), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
    .resp_reserved(resp_reserved));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic go(input logic w, input logic [15:0] a, input logic [31:0] d,
                    input logic ns, input logic res, input logic [31:0] x);
    logic [33:0] r, e;
    e = {1'b1, res, (res || w) ? 32'h0 : x};
    host.acc(w, a, d, ns, r);
    num_checks++;
    if (r !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, r, e);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize;
    end
  end
  initial begin
    rs = 32'd44054;
    repeat (20) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    for (int ns = 0; ns < 2; ns++) begin
      go(0, `PMRP_OFF_FEATURE_ID, 0, ns[0], 0, `PMRP_FEATURE_VAL);
      go(0, `PMRP_OFF_IMPL_ID, 0, ns[0], 0, `PMRP_IMPL_ID_VAL);
      go(0, `PMRP_OFF_ARCH_ID, 0, ns[0], 0, `PMRP_ARCH_ID_VAL);
      go(0, `PMRP_OFF_MON_FEAT_ID, 0, ns[0], 0, `PMRP_MON_FEAT_VAL);
      go(0, `PMRP_OFF_SEC_FEAT_ID, 0, ns[0], ns[0], `PMRP_SEC_FEAT_VAL);
      go(1, `PMRP_OFF_IMPL_ID, 32'h1, ns[0], 1, 0);
    end
    // select then access, write pass then read-back pass per bank and index
    for (int k = 0; k < 5; k++) for (int p = 0; p < 2; p++) for (int i = 0; i < 16; i++)
      if ((i >> 1) < ((k % 3 == 0) ? 8 : 4)) begin
        go(1, (k % 3 == 0) ? `PMRP_OFF_PART_SEL : `PMRP_OFF_MON_SEL, i >> 1, i[0], 0, 0);
        if (p == 0) begin
          rs = xs(rs);
          v[k][i] = rs;
        end
        go(p == 0, off[k], v[k][i], i[0], 0, v[k][i]);
      end
    go(1, `PMRP_OFF_MON_SEL, 1, 0, 0, 0);
    go(1, `PMRP_OFF_MON_SEL, 2, 1, 0, 0);
    go(0, `PMRP_OFF_MON_SEL, 0, 0, 0, 1);
    go(0, `PMRP_OFF_MON_SEL, 0, 1, 0, 2);
    go(0, `PMRP_OFF_CSU_CTL, 0, 0, 0, v[1][2]);
    go(0, `PMRP_OFF_CSU_CTL, 0, 1, 0, v[1][5]);
    for (int m = 0; m < 4; m++) begin
      go(1, `PMRP_OFF_MON_SEL, m, m[1], 0, 0);
      go(1, `PMRP_OFF_CSU_CTL, {m[0], 31'h0}, m[1], 0, 0);
      go(1, `PMRP_OFF_CSU_CNT, 32'h5, m[1], 0, 0);
      @(negedge clk) mon_event = 1'b1;
      @(negedge clk) mon_event = 1'b0;
      go(0, `PMRP_OFF_CSU_CNT, 0, m[1], 0, 32'h5 + m[0]);
    end
    for (int j = 0; j < 15; j++) begin
      rs = xs(rs);
      go(rs[16], j < 12 ? 16'h3000 + rs[15:0] % 16'hD000 : 16'h0200 + j, rs, rs[17], 1, 0);
    end
    go(1, `PMRP_OFF_MON_SEL, 2, 0, 0, 0);
    go(0, `PMRP_OFF_CSU_FLT, 0, 0, 0, v[2][4]);
    go(1, `PMRP_OFF_PART_SEL, 8, 1, 0, 0);
    go(1, `PMRP_OFF_MON_SEL, 4, 0, 0, 0);
    go(0, `PMRP_OFF_ERR_STAT, 0, 1, 0, `PMRP_ERR_SEL_RANGE);
    go(0, `PMRP_OFF_ERR_STAT, 0, 0, 0, `PMRP_ERR_MON_RANGE);
    go(0, `PMRP_OFF_PART_SEL, 0, 1, 0, 0);
    rs = xs(rs);
    go(1, `PMRP_OFF_ERR_CTL, rs, 0, 0, 0);
    go(0, `PMRP_OFF_ERR_CTL, 0, 1, 0, 0);
    go(0, `PMRP_OFF_ERR_CTL, 0, 0, 0, rs);
    summarize;
  end
endmodule // testbench
`default_nettype wire
